// ---- logic/rtcdc_cfg.svh ----
// constants of the real-time clock divider chain
`ifndef RTCDC_CFG_SVH
`define RTCDC_CFG_SVH
`define RTCDC_DIV32_W 5
`define RTCDC_DIV8_W 3
`define RTCDC_PRE_W 16
`define RTCDC_CNT_W 32
`define RTCDC_WORD_W 16
`define RTCDC_NSEC 4
`define RTCDC_NSTG 5
`define RTCDC_S0_W 10
`define RTCDC_S1_W 6
`define RTCDC_S2_W 6
`define RTCDC_S3_W 10
`define RTCDC_S0_LSB 0
`define RTCDC_S1_LSB 10
`define RTCDC_S2_LSB 16
`define RTCDC_S3_LSB 22
`endif

// ---- logic/rtcdc_pkg.sv ----
// types of the real-time clock divider chain
`default_nettype none
`include "rtcdc_cfg.svh"
package rtcdc_pkg;
  // source of the chain's base tick
  typedef enum logic [1:0] {
    RTCDC_SRC_CORE,
    RTCDC_SRC_INT_TICK,
    RTCDC_SRC_EXT_PIN
  } rtcdc_src_t;

  // reload values for the prescale timer and the four count sections
  typedef struct packed {
    logic [`RTCDC_PRE_W-1:0] pre;
    logic [`RTCDC_CNT_W-1:0] sec;
  } rtcdc_reload_t;

  // readable count words
  typedef struct packed {
    logic [`RTCDC_WORD_W-1:0] count_high_word;
    logic [`RTCDC_WORD_W-1:0] count_low_word;
  } rtcdc_count_t;
endpackage
`default_nettype wire

// ---- logic/rtcdc_stage.sv ----
// one reloadable up-counting divider stage
`timescale 1ns/1ns
`default_nettype none
module rtcdc_stage #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         inc,
  input  wire logic [W-1:0] reload,
  output var  logic [W-1:0] cnt_q,
  output wire logic         ovf
);
  // overflow is combinational so the next stage counts in the same cycle
  assign ovf = inc && (&cnt_q);

  // count up, reload on overflow; only the power reset clears it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (ovf) begin
      cnt_q <= reload;
    end else if (inc) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- logic/rtcdc_top.sv ----
// real-time clock divider chain: source select, prescalers, timers, interrupts
//
// Functional notes
// - software picks the chain clock: core clock, internal tick or external pin.
// - divide-by-32 and divide-by-8 prescalers, each switched in or out independently.
// - a 16-bit reloadable prescale timer follows the prescalers and feeds the count.
// - 32-bit count from 10, 6, 6, 10-bit reloadable sections, read as two words.
// - every timer and section counts up by one per tick from its predecessor.
// - each timer stage raises its own request when it overflows.
// - stage requests enabled by irq_en merge into one shared request output.
// - only the power reset clears the chain's state; other resets leave it alone.
`timescale 1ns/1ns
`default_nettype none
`include "rtcdc_cfg.svh"
module rtcdc_top (
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire rtcdc_pkg::rtcdc_src_t         clk_sel,
  input  wire logic                          int_tick,
  input  wire logic                          ext_clk_pin,
  input  wire logic                          div32_en,
  input  wire logic                          div8_en,
  input  wire rtcdc_pkg::rtcdc_reload_t      reload,
  input  wire logic [`RTCDC_NSTG-1:0]        irq_en,
  input  wire logic [`RTCDC_NSTG-1:0]        irq_clr,
  output var  logic [`RTCDC_PRE_W-1:0]       prescale_timer,
  output var  rtcdc_pkg::rtcdc_count_t       count,
  output var  logic [`RTCDC_NSTG-1:0]        irq_flag_q,
  output var  logic                          irq_req_q
);
  import rtcdc_pkg::*;

  localparam int SEC_W [`RTCDC_NSEC]   = '{`RTCDC_S0_W, `RTCDC_S1_W, `RTCDC_S2_W, `RTCDC_S3_W};
  localparam int SEC_LSB [`RTCDC_NSEC] = '{`RTCDC_S0_LSB, `RTCDC_S1_LSB, `RTCDC_S2_LSB, `RTCDC_S3_LSB};

  logic                       ext_s1_q;
  logic                       ext_s2_q;
  logic                       ext_s3_q;
  logic                       src_tick;
  logic [`RTCDC_DIV32_W-1:0]  div32_cnt;
  logic                       div32_ovf;
  logic                       div32_tick;
  logic [`RTCDC_DIV8_W-1:0]   div8_cnt;
  logic                       div8_ovf;
  logic                       pre_tick;
  logic                       pre_ovf;
  logic [`RTCDC_NSEC:0]       carry;
  logic [`RTCDC_CNT_W-1:0]    count_all;
  logic [`RTCDC_NSTG-1:0]     stg_evt;

  // external pin passes two flops; the third only serves the edge detector
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_clk_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // base tick selection; pin clock must stay below half the core rate
  always_comb begin
    unique case (clk_sel)
      RTCDC_SRC_CORE:     src_tick = 1'b1;
      RTCDC_SRC_INT_TICK: src_tick = int_tick;
      RTCDC_SRC_EXT_PIN:  src_tick = ext_s2_q && !ext_s3_q;
      default:            src_tick = 1'b0;
    endcase
  end

  // prescalers: a switched-out divider freezes and its input passes straight on
  rtcdc_stage #(.W(`RTCDC_DIV32_W)) u_div32 (
    .core_clk (core_clk),
    .rst      (rst),
    .inc      (src_tick && div32_en),
    .reload   ('0),
    .cnt_q    (div32_cnt),
    .ovf      (div32_ovf)
  );
  assign div32_tick = div32_en ? div32_ovf : src_tick;

  rtcdc_stage #(.W(`RTCDC_DIV8_W)) u_div8 (
    .core_clk (core_clk),
    .rst      (rst),
    .inc      (div32_tick && div8_en),
    .reload   ('0),
    .cnt_q    (div8_cnt),
    .ovf      (div8_ovf)
  );
  assign pre_tick = div8_en ? div8_ovf : div32_tick;

  // 16-bit prescale timer drives the count sections
  rtcdc_stage #(.W(`RTCDC_PRE_W)) u_pre (
    .core_clk (core_clk),
    .rst      (rst),
    .inc      (pre_tick),
    .reload   (reload.pre),
    .cnt_q    (prescale_timer),
    .ovf      (pre_ovf)
  );
  assign carry[0]   = pre_ovf;
  assign stg_evt[0] = pre_ovf;

  // four chained sections; each overflow is the next section's tick
  for (genvar i = 0; i < `RTCDC_NSEC; i++) begin : g_sec
    // plain per-section constants keep the checks below readable
    localparam int SW = SEC_W[i];
    localparam int SL = SEC_LSB[i];

    rtcdc_stage #(.W(SEC_W[i])) u_sec (
      .core_clk (core_clk),
      .rst      (rst),
      .inc      (carry[i]),
      .reload   (reload.sec[SEC_LSB[i] +: SEC_W[i]]),
      .cnt_q    (count_all[SEC_LSB[i] +: SEC_W[i]]),
      .ovf      (carry[i+1])
    );
    assign stg_evt[i+1] = carry[i+1];

    // a section that is ticked without wrapping moves up by exactly one
    AST_SEC_UP: assert property (@(posedge core_clk) disable iff (rst)
      carry[i] && !carry[i+1] |=> count_all[SL +: SW] == SW'($past(count_all[SL +: SW]) + 1'b1))
      else $error("count section did not step up by one");

    // a wrapping section restarts from its own reload field, not from zero
    AST_SEC_RELOAD: assert property (@(posedge core_clk) disable iff (rst)
      carry[i+1] |=> count_all[SL +: SW] == $past(reload.sec[SL +: SW]))
      else $error("count section did not reload on overflow");
  end

  // word view of the 32-bit count
  assign count.count_low_word  = count_all[`RTCDC_WORD_W-1:0];
  assign count.count_high_word = count_all[`RTCDC_CNT_W-1:`RTCDC_WORD_W];

  // sticky flags; a stage event in the clear cycle wins so no overflow is lost
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_flag_q <= '0;
    end else begin
      irq_flag_q <= (irq_flag_q & ~irq_clr) | stg_evt;
    end
  end

  // shared request from enabled flags, registered for a clean output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_req_q <= 1'b0;
    end else begin
      irq_req_q <= |(irq_flag_q & irq_en);
    end
  end

  // checks
  sequence s_pre_wrap;
    pre_ovf;
  endsequence

  sequence s_pre_reloaded;
    prescale_timer == $past(reload.pre);
  endsequence

  // a stage overflows in the very cycle in which its flag is cleared
  sequence s_set_and_clear;
    |(stg_evt & irq_clr);
  endsequence

  AST_SRC_CORE: assert property (@(posedge core_clk) disable iff (rst)
    clk_sel == RTCDC_SRC_CORE |-> src_tick)
    else $error("core source gave no tick");

  // the spare source code is the way software stops the chain
  AST_SEL_OFF: assert property (@(posedge core_clk) disable iff (rst)
    !(clk_sel inside {RTCDC_SRC_CORE, RTCDC_SRC_INT_TICK, RTCDC_SRC_EXT_PIN}) |-> !src_tick)
    else $error("unused source code gave a tick");

  AST_EXT_EDGE: assert property (@(posedge core_clk) disable iff (rst)
    clk_sel == RTCDC_SRC_EXT_PIN && src_tick |-> $past(ext_clk_pin, 2) && !$past(ext_clk_pin, 3))
    else $error("pin tick without a synchronised rising edge");

  AST_BYPASS: assert property (@(posedge core_clk) disable iff (rst)
    !div32_en && !div8_en |-> pre_tick == src_tick)
    else $error("switched-out prescalers altered the tick");

  AST_DIV32: assert property (@(posedge core_clk) disable iff (rst)
    div32_en && !div8_en && pre_tick |-> src_tick && div32_cnt == '1)
    else $error("divide-by-32 passed a tick early");

  AST_DIV8: assert property (@(posedge core_clk) disable iff (rst)
    !div32_en && div8_en && pre_tick |-> src_tick && div8_cnt == '1)
    else $error("divide-by-8 passed a tick early");

  // a switched-out divider keeps its phase for when it is switched back in
  AST_DIV_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    !div32_en && !div8_en |=> $stable(div32_cnt) && $stable(div8_cnt))
    else $error("switched-out divider moved");

  AST_PRE_RELOAD: assert property (@(posedge core_clk) disable iff (rst)
    s_pre_wrap |=> s_pre_reloaded)
    else $error("prescale timer did not reload on overflow");

  AST_CARRY: assert property (@(posedge core_clk) disable iff (rst)
    carry[1] |-> pre_ovf && count_all[`RTCDC_S0_W-1:0] == '1)
    else $error("first section wrapped without a carry");

  AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (rst)
    stg_evt[0] |=> irq_flag_q[0] ##1 (irq_flag_q[0] || $past(irq_clr[0])))
    else $error("stage event did not set its flag");

  AST_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
    irq_clr[0] && !stg_evt[0] |=> !irq_flag_q[0])
    else $error("flag survived a clear");

  // losing an overflow to a racing clear would hide an event from software
  AST_SET_WINS: assert property (@(posedge core_clk) disable iff (rst)
    s_set_and_clear |=> (irq_flag_q & $past(stg_evt & irq_clr)) == $past(stg_evt & irq_clr))
    else $error("clear in the overflow cycle lost the flag");

  AST_REQ: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> irq_req_q == |($past(irq_flag_q) & $past(irq_en)))
    else $error("shared request does not follow enabled flags");

  AST_MASKED: assert property (@(posedge core_clk) disable iff (rst)
    (irq_flag_q & irq_en) == '0 |=> !irq_req_q)
    else $error("disabled flags raised the shared request");

  AST_STILL: assert property (@(posedge core_clk) disable iff (rst)
    !pre_tick |=> $stable(prescale_timer) && $stable(count_all))
    else $error("chain moved without a tick");
endmodule
`default_nettype wire

// ---- bench/rtcdc_top_test.sv ----
// lockstep self-checking bench of the real-time clock divider chain
`timescale 1ns/1ns
`default_nettype none
module rtcdc_top_test;
  import rtcdc_pkg::*;
  logic          core_clk, rst, int_tick, ext_clk_pin, div32_en, div8_en, chk, req, req_o;
  rtcdc_src_t    clk_sel;
  rtcdc_reload_t reload;
  rtcdc_count_t  cnt;
  logic [4:0]    irq_en, irq_clr, fl, fl_o, c32;
  logic [2:0]    c8;
  logic [15:0]   p, pt;
  logic [31:0]   s;
  int            miscompares = 0;
  int            n_compared = 0;
  int            cyc = 0;
  int            w[4] = '{10, 6, 6, 10};
  int            lo[4] = '{0, 10, 16, 22};

  rtcdc_top i_rtcdc_top (.core_clk(core_clk), .rst(rst), .clk_sel(clk_sel), .int_tick(int_tick),
    .ext_clk_pin(ext_clk_pin), .div32_en(div32_en), .div8_en(div8_en), .reload(reload), .irq_en(irq_en),
    .irq_clr(irq_clr), .prescale_timer(pt), .count(cnt), .irq_flag_q(fl_o), .irq_req_q(req_o));

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one tick through the reference chain; a switched-in stage passes a tick on only as it wraps
  task automatic step(input logic t);
    logic [4:0]  ov;
    logic [31:0] m;
    ov = '0;
    if (t && div32_en) begin
      c32 = c32 + 5'h1;
      t = (c32 == 5'h0);
    end
    if (t && div8_en) begin
      c8 = c8 + 3'h1;
      t = (c8 == 3'h0);
    end
    if (t) begin
      ov[0] = &p;
      p = ov[0] ? reload.pre : p + 16'h1;
    end
    for (int i = 0; i < 4; i++) begin
      m = ((32'h1 << w[i]) - 32'h1) << lo[i];
      if (ov[i]) begin
        ov[i+1] = (s & m) == m;
        s = ov[i+1] ? (s & ~m) | (reload.sec & m) : s + (32'h1 << lo[i]);
      end
    end
    req = |(fl & irq_en);
    fl = (fl & ~irq_clr) | ov;
  endtask

  // reference chain advances on the same edges as the design
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {c32, c8, p, s, fl, req} = '0;
    end else begin
      step(clk_sel == RTCDC_SRC_CORE || (clk_sel == RTCDC_SRC_INT_TICK && int_tick));
    end
  end

  // compare every settled cycle; off during the first reset and while pin ticks have unknown sync latency
  always @(negedge core_clk) begin
    if (chk) begin
      check(32'(pt), 32'(p));
      check(cnt, s);
      check(32'(fl_o), 32'(fl));
      check(32'(req_o), 32'(req));
    end
  end

  // hang guard, a little above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 95000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // long core-clock run until the top section wraps at least once
  task automatic t_core;
    reload <= '{pre: 16'hfffe, sec: {10'h3fe, 6'h3e, 6'h3e, 10'h3fe}};
    irq_en <= 5'h1f;
    clk_sel <= RTCDC_SRC_CORE;
    repeat (85000) @(posedge core_clk);
  endtask

  // chain stopped: masking and clearing of sticky flags
  task automatic t_irq;
    clk_sel <= rtcdc_src_t'(2'h3);
    irq_en <= 5'h0a;
    repeat (3) @(posedge core_clk);
    irq_clr <= 5'h05;
    @(posedge core_clk);
    irq_clr <= 5'h1a;
    @(posedge core_clk);
    irq_clr <= 5'h00;
    repeat (3) @(posedge core_clk);
  endtask

  // internal tick through divide-by-32 alone, divide-by-8 alone and both dividers, clears racing with sets
  task automatic t_div;
    irq_en <= 5'h1f;
    clk_sel <= RTCDC_SRC_INT_TICK;
    for (int k = 1; k < 4; k++) begin
      {div8_en, div32_en} <= 2'(k);
      for (int j = 0; j < 600; j++) begin
        int_tick <= j[0] | j[3];
        irq_clr <= (j % 7 == 0) ? 5'h1f : 5'h00;
        @(posedge core_clk);
      end
    end
    irq_clr <= 5'h00;
  endtask

  // pin clock: count pin rises, then replay them into the reference
  task automatic t_ext;
    {div8_en, div32_en} <= 2'h0;
    clk_sel <= RTCDC_SRC_EXT_PIN;
    chk <= 1'b0;
    repeat (20) begin
      ext_clk_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      ext_clk_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (8) @(posedge core_clk);
    clk_sel <= rtcdc_src_t'(2'h3);
    @(negedge core_clk);
    repeat (20) step(1'b1);
    check(32'(pt), 32'(p));
    repeat (2) @(posedge core_clk);
    chk <= 1'b1;
  endtask

  // power reset in mid-run clears everything, counting restarts after it
  task automatic t_reset;
    clk_sel <= RTCDC_SRC_CORE;
    repeat (50) @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check({pt, 11'h0, fl_o}, 32'h0);
    check(cnt, 32'h0);
    check(32'(req_o), 32'h0);
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (100) @(posedge core_clk);
  endtask

  initial begin
    {rst, int_tick, ext_clk_pin, div32_en, div8_en, chk} = 6'h20;
    clk_sel = rtcdc_src_t'(2'h3);
    reload = '0;
    irq_en = 5'h00;
    irq_clr = 5'h00;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    chk <= 1'b1;
    t_core();
    t_irq();
    t_div();
    t_ext();
    t_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
